// File: isb_bus.sv
// ISA-style system bus command engine with DMA handshake pins
`timescale 1ns/10ps
// Function
// - Drive I/O read strobe for I/O reads
// - Drive I/O write strobe during I/O writes
// - Drive memory read strobe for memory reads
// - Drive memory write strobe during memory writes
// - Wide-target feedback marks a 16-bit target
// - Ready low extends the current bus cycle
// - Four DMA request inputs ask for transfers
// - Acknowledge only after processor releases bus
// - Shared pin: count output or end input
// - Pulse count pin at terminal count in output mode only
// - Upper byte enable when odd byte moves
// - Upper data byte unused for 8-bit targets
module isb_bus (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire isb_pkg::isb_kind_type req_kind_i,
  input wire logic req_write_i,
  input wire logic req_word_i,
  input wire logic req_odd_i,
  input wire logic [isb_pkg::DATA_W-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [isb_pkg::DATA_W-1:0] rsp_rdata_o,
  output logic rsp_wide_o,
  input wire logic [isb_pkg::DATA_W-1:0] system_data_lines_i,
  output logic [isb_pkg::DATA_W-1:0] system_data_lines_o,
  output logic data_lo_oe_n_o,
  output logic data_hi_oe_n_o,
  output logic upper_byte_enable_n_o,
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic mem_read_strobe_n_o,
  output logic mem_write_strobe_n_o,
  input wire logic wide_target_n_i,
  input wire logic ready_i,
  input wire logic [isb_pkg::DMA_CH-1:0] dma_request_i,
  output logic [isb_pkg::DMA_CH-1:0] dma_grant_n_o,
  output logic bus_hold_req_o,
  input wire logic bus_hold_ack_i,
  input wire logic dma_count_done_i,
  input wire logic pin_out_mode_i,
  input wire logic process_end_n_i,
  output logic count_done_pulse_o,
  output logic count_done_pulse_oe_n_o,
  output logic dma_end_o
);
  import isb_pkg::*;

  // ---------------------------------------------------------------
  // DMA side
  // ---------------------------------------------------------------
  isb_dma_if dma_bus ();

  assign dma_bus.req = dma_request_i;
  assign dma_bus.hold_ack = bus_hold_ack_i;
  assign dma_bus.count_done = dma_count_done_i;
  assign dma_bus.out_mode = pin_out_mode_i;
  assign dma_grant_n_o = dma_bus.grant_n;
  assign bus_hold_req_o = dma_bus.hold_req;
  assign dma_end_o = dma_bus.end_seen;

  isb_dma_arb u_arb (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .dma(dma_bus.arb)
  );

  isb_count_pin u_pin (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .dma(dma_bus.term),
    .process_end_n_i(process_end_n_i),
    .count_done_pulse_o(count_done_pulse_o),
    .count_done_pulse_oe_n_o(count_done_pulse_oe_n_o)
  );

  // ---------------------------------------------------------------
  // Command engine state
  // ---------------------------------------------------------------
  isb_state_type state_r;
  isb_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  isb_kind_type kind_r;
  logic write_r;
  logic word_r;
  logic odd_r;
  logic wide_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] strb_r;
  logic upper_en_r;
  logic [DATA_W-1:0] data_out_r;
  logic lo_oe_r;
  logic hi_oe_r;
  logic rsp_valid_r;
  logic [DATA_W-1:0] rdata_r;
  logic rsp_wide_r;

  logic dma_busy;
  logic start;
  logic cnt_done;
  logic cmd_end;
  logic hi_moves;
  logic [3:0] strb_sel;
  logic [3:0] strb_nxt;
  logic in_cycle_nxt;
  logic wide_now;
  logic [7:0] lo_byte;
  logic [DATA_W-1:0] rdata_nxt;

  // New cycles wait while the bus is requested by or handed to DMA
  assign dma_busy = dma_bus.hold_req || (dma_bus.grant_n != GRANT_NONE_N);
  assign req_ready_o = (state_r == ST_IDLE) && !dma_busy;
  assign start = req_valid_i && req_ready_o;
  assign cnt_done = (cnt_r == CNT_ZERO);
  assign cmd_end = (state_r == ST_CMD) && cnt_done && ready_i;
  assign hi_moves = odd_r || word_r;

  assign strb_sel[STRB_IO_RD] = (kind_r == KIND_IO) && !write_r;
  assign strb_sel[STRB_IO_WR] = (kind_r == KIND_IO) && write_r;
  assign strb_sel[STRB_MEM_RD] = (kind_r == KIND_MEM) && !write_r;
  assign strb_sel[STRB_MEM_WR] = (kind_r == KIND_MEM) && write_r;
  // Exactly one select bit is set, so one strobe at most
  assign strb_nxt = (state_nxt == ST_CMD) ? strb_sel : STRB_NONE;

  assign in_cycle_nxt = (state_nxt != ST_IDLE);
  // Target width is latched as the setup phase hands over to command
  assign wide_now = (state_r == ST_SETUP) ? !wide_target_n_i : wide_r;

  // An 8-bit target sees the odd byte on the low lane
  assign lo_byte = (odd_r && !wide_now) ? wdata_r[15:8] : wdata_r[7:0];
  assign rdata_nxt = (wide_r && word_r) ? system_data_lines_i :
                     (wide_r && odd_r) ? {system_data_lines_i[15:8], BYTE_ZERO} :
                     odd_r ? {system_data_lines_i[7:0], BYTE_ZERO} :
                     {BYTE_ZERO, system_data_lines_i[7:0]};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_done) begin
          state_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cmd_end) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencing registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        cnt_r <= SETUP_LOAD;
      end else if (state_r == ST_SETUP && cnt_done) begin
        cnt_r <= CMD_LOAD;
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      kind_r <= KIND_IO;
      write_r <= 1'b0;
      word_r <= 1'b0;
      odd_r <= 1'b0;
      wdata_r <= DATA_RST;
      wide_r <= 1'b0;
    end else begin
      if (start) begin
        kind_r <= req_kind_i;
        write_r <= req_write_i;
        word_r <= req_word_i;
        odd_r <= req_odd_i;
        wdata_r <= req_wdata_i;
      end
      wide_r <= wide_now;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strb_r <= STRB_NONE;
      upper_en_r <= 1'b0;
      data_out_r <= DATA_RST;
      lo_oe_r <= 1'b0;
      hi_oe_r <= 1'b0;
    end else begin
      strb_r <= strb_nxt;
      upper_en_r <= in_cycle_nxt && (start ? (req_odd_i || req_word_i) : hi_moves);
      data_out_r <= {wdata_r[15:8], lo_byte};
      lo_oe_r <= in_cycle_nxt && !start && write_r;
      // Upper lane stays quiet for 8-bit targets
      hi_oe_r <= in_cycle_nxt && !start && write_r && wide_now && hi_moves;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp_valid_r <= 1'b0;
      rdata_r <= DATA_RST;
      rsp_wide_r <= 1'b0;
    end else begin
      rsp_valid_r <= cmd_end;
      if (cmd_end) begin
        rdata_r <= write_r ? DATA_RST : rdata_nxt;
        rsp_wide_r <= wide_r;
      end
    end
  end

  assign io_read_strobe_n_o = !strb_r[STRB_IO_RD];
  assign io_write_strobe_n_o = !strb_r[STRB_IO_WR];
  assign mem_read_strobe_n_o = !strb_r[STRB_MEM_RD];
  assign mem_write_strobe_n_o = !strb_r[STRB_MEM_WR];
  assign upper_byte_enable_n_o = !upper_en_r;
  assign system_data_lines_o = data_out_r;
  assign data_lo_oe_n_o = !lo_oe_r;
  assign data_hi_oe_n_o = !hi_oe_r;
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_rdata_o = rdata_r;
  assign rsp_wide_o = rsp_wide_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_cmd_open;
    $rose(state_r == ST_CMD);
  endsequence

  sequence s_min_strobe;
    (strb_r != STRB_NONE) [*3];
  endsequence

  property p_io_read;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_CMD && kind_r == KIND_IO && !write_r) |-> !io_read_strobe_n_o && io_write_strobe_n_o;
  endproperty
  a_io_read: assert property (p_io_read) else $error("I/O read strobe wrong");

  property p_io_write;
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(io_write_strobe_n_o) |-> (kind_r == KIND_IO && write_r && $past(state_r) == ST_SETUP && !data_lo_oe_n_o);
  endproperty
  a_io_write: assert property (p_io_write) else $error("I/O write strobe without write");

  property p_mem_read;
    @(posedge ref_clk_i) disable iff (rst_i)
    !mem_read_strobe_n_o |-> (state_r == ST_CMD && kind_r == KIND_MEM && !write_r);
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory read strobe out of cycle");

  property p_mem_write;
    @(posedge ref_clk_i) disable iff (rst_i)
    (s_cmd_open and (kind_r == KIND_MEM && write_r)) |-> !mem_write_strobe_n_o;
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("memory write strobe missing");

  property p_wide_sample;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_cmd_open |-> (wide_r == !$past(wide_target_n_i));
  endproperty
  a_wide_sample: assert property (p_wide_sample) else $error("target width not taken");

  property p_wait_state;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_CMD && !ready_i) |=> (state_r == ST_CMD && $stable(strb_r));
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("cycle not extended");

  property p_end_on_ready;
    @(posedge ref_clk_i) disable iff (rst_i)
    ($past(strb_r) != STRB_NONE && strb_r == STRB_NONE) |-> ($past(ready_i) && rsp_valid_o);
  endproperty
  a_end_on_ready: assert property (p_end_on_ready) else $error("strobe ended without ready");

  property p_min_strobe;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_cmd_open |-> s_min_strobe;
  endproperty
  a_min_strobe: assert property (p_min_strobe) else $error("command strobe too short");

  property p_one_strobe;
    @(posedge ref_clk_i) disable iff (rst_i)
    $onehot0({io_read_strobe_n_o, io_write_strobe_n_o, mem_read_strobe_n_o, mem_write_strobe_n_o} ^ 4'hF);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two command strobes at once");

  property p_upper_enable;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_r != ST_IDLE) |-> (upper_byte_enable_n_o == !(odd_r || word_r));
  endproperty
  a_upper_enable: assert property (p_upper_enable) else $error("upper byte enable wrong");

  property p_narrow_lane;
    @(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_CMD && !wide_r) |-> data_hi_oe_n_o;
  endproperty
  a_narrow_lane: assert property (p_narrow_lane) else $error("upper lane driven for 8-bit target");
endmodule

// File: isb_dma_arb.sv
// Fixed-priority DMA request arbiter with bus-hold handshake and acknowledges
`timescale 1ns/10ps
module isb_dma_arb (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  isb_dma_if.arb dma
);
  import isb_pkg::*;

  logic hold_r;
  logic granted_r;
  logic [3:0] win_r;
  logic [3:0] win_nxt;
  logic any_req;
  logic drop;

  // Channel 0 has the highest priority
  assign win_nxt = dma.req & (~dma.req + 4'h1);
  assign any_req = |dma.req;
  // Grant ends when the winner drops its request or the transfer ends
  assign drop = granted_r && (((win_r & dma.req) == STRB_NONE) || dma.end_seen);
  assign dma.hold_req = hold_r;
  assign dma.grant_n = granted_r ? ~win_r : GRANT_NONE_N;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_r <= 1'b0;
      granted_r <= 1'b0;
      win_r <= STRB_NONE;
    end else if (drop) begin
      hold_r <= 1'b0;
      granted_r <= 1'b0;
    end else if (!granted_r) begin
      hold_r <= any_req;
      if (hold_r && dma.hold_ack && any_req) begin
        granted_r <= 1'b1;
        win_r <= win_nxt;
      end
    end
  end

  property p_grant_after_release;
    @(posedge ref_clk_i) disable iff (rst_i)
    (dma.grant_n != GRANT_NONE_N) |-> (dma.hold_ack && hold_r && $onehot(~dma.grant_n));
  endproperty
  a_grant_after_release: assert property (p_grant_after_release) else $error("ack without bus release");

  property p_grant_follows_request;
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(dma.grant_n[0]) |-> $past(dma.req[0]);
  endproperty
  a_grant_follows_request: assert property (p_grant_follows_request) else $error("ack without request");
endmodule

// File: isb_dma_if.sv
// DMA handshake and shared terminal-count pin signals between bus modules
`timescale 1ns/10ps
interface isb_dma_if;
  logic [3:0] req;
  logic hold_req;
  logic hold_ack;
  logic [3:0] grant_n;
  logic count_done;
  logic out_mode;
  logic end_seen;

  modport arb (input req, input hold_ack, input end_seen, output hold_req, output grant_n);
  modport term (input count_done, input out_mode, output end_seen);
  modport top (output req, output hold_ack, output count_done, output out_mode,
               input hold_req, input grant_n, input end_seen);
endinterface

// File: isb_periph_model.sv
// Behavioural ISA-style peripheral answering the bus engine's command strobes
`timescale 1ns/10ps
module isb_periph_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] drv_data_i,
  input wire logic drv_lo_oe_n_i,
  input wire logic drv_hi_oe_n_i,
  input wire logic io_read_strobe_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic mem_read_strobe_n_i,
  input wire logic mem_write_strobe_n_i,
  input wire logic wide_en_i,
  input wire logic [3:0] wait_cnt_i,
  input wire logic [15:0] rd_pattern_i,
  output logic [15:0] bus_o,
  output logic wide_target_n_o,
  output logic ready_o,
  output logic [15:0] wr_seen_o
);
  logic [15:0] last_r = 16'h0000;
  logic [4:0] low_cnt_r = 5'h00;
  wire rd_n = io_read_strobe_n_i & mem_read_strobe_n_i;
  wire wr_n = io_write_strobe_n_i & mem_write_strobe_n_i;
  // Released lines show the inverse of the last value, never a stale copy
  wire [15:0] idle_val = ~last_r;
  wire [7:0] lo_byte = !drv_lo_oe_n_i ? drv_data_i[7:0] : !rd_n ? rd_pattern_i[7:0] : idle_val[7:0];
  // Narrow targets leave the upper byte alone
  wire [7:0] hi_byte = !drv_hi_oe_n_i ? drv_data_i[15:8] :
                       (!rd_n && wide_en_i) ? rd_pattern_i[15:8] : idle_val[15:8];
  wire wait_win = low_cnt_r >= 5'h02 && low_cnt_r < 5'(wait_cnt_i) + 5'h02;

  assign bus_o = {hi_byte, lo_byte};
  assign wide_target_n_o = !wide_en_i;
  assign ready_o = !(!(rd_n & wr_n) && wait_win);

  always @(posedge ref_clk_i) begin
    last_r <= bus_o;
    low_cnt_r <= (rd_n & wr_n) ? 5'h00 : low_cnt_r + 5'h01;
    if (!wr_n) begin
      wr_seen_o <= bus_o;
    end
  end
endmodule

// File: isb_pkg.sv
// Shared constants and types for the ISA-style system bus controller
package isb_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SETUP_NS = 10;
  localparam int T_CMD_MIN_NS = 15;
  // Least times, rounded up to whole cycles, never below one
  localparam int SETUP_CYC = ((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                             ((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CMD_CYC = ((T_CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                           ((T_CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] CMD_LOAD = CNT_W'(CMD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  // ---------------------------------------------------------------
  // Widths, strobe positions, reset values
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int DMA_CH = 4;
  localparam int STRB_IO_RD = 0;
  localparam int STRB_IO_WR = 1;
  localparam int STRB_MEM_RD = 2;
  localparam int STRB_MEM_WR = 3;
  localparam logic [3:0] STRB_NONE = 4'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] GRANT_NONE_N = 4'hF;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    KIND_IO = 1'b0,
    KIND_MEM = 1'b1
  } isb_kind_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_CMD = 4'h4,
    ST_HOLD = 4'h8
  } isb_state_type;

endpackage

// File: isb_tc_pin.sv
// Shared terminal-count output / end-of-process input pin
`timescale 1ns/10ps
module isb_count_pin (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  isb_dma_if.term dma,
  input wire logic process_end_n_i,
  output logic count_done_pulse_o,
  output logic count_done_pulse_oe_n_o
);
  import isb_pkg::*;

  logic pulse_r;
  logic prev_r;
  logic end_r;
  logic fall;

  assign fall = !dma.out_mode && prev_r && !process_end_n_i;
  assign count_done_pulse_o = pulse_r;
  assign count_done_pulse_oe_n_o = !dma.out_mode;
  assign dma.end_seen = end_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
      prev_r <= 1'b1;
      end_r <= 1'b0;
    end else begin
      pulse_r <= dma.out_mode && dma.count_done;
      // Input mode only; a driven pin would read back our own level
      prev_r <= dma.out_mode ? 1'b1 : process_end_n_i;
      end_r <= fall;
    end
  end

  property p_count_pulse;
    @(posedge ref_clk_i) disable iff (rst_i)
    (dma.out_mode && dma.count_done) |=> (count_done_pulse_o && !count_done_pulse_oe_n_o);
  endproperty
  a_count_pulse: assert property (p_count_pulse) else $error("terminal count pulse missing");

  property p_end_input;
    @(posedge ref_clk_i) disable iff (rst_i)
    dma.end_seen |-> ($past(!dma.out_mode) && $past(process_end_n_i, 2) && !$past(process_end_n_i));
  endproperty
  a_end_input: assert property (p_end_input) else $error("end of process misread");
endmodule

// File: tb_top.sv
// Self-checking testbench for the system bus command engine
`timescale 1ns/10ps
module tb_top;
  import isb_pkg::*;
  localparam logic [15:0] RD_PAT = 16'hC3A5;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0, req_word_i = 1'b0;
  logic req_odd_i = 1'b0, bus_hold_ack_i = 1'b0, dma_count_done_i = 1'b0, pin_out_mode_i = 1'b1;
  logic process_end_n_i = 1'b1, wide_en = 1'b0, upper_seen = 1'b0;
  isb_kind_type req_kind_i = KIND_IO;
  logic [15:0] req_wdata_i = 16'h0000;
  logic [3:0] dma_request_i = 4'h0, wait_cnt = 4'h0, strb_seen = 4'h0;
  logic req_ready_o, rsp_valid_o, rsp_wide_o, data_lo_oe_n_o, data_hi_oe_n_o, upper_byte_enable_n_o;
  logic io_read_strobe_n_o, io_write_strobe_n_o, mem_read_strobe_n_o, mem_write_strobe_n_o;
  logic wide_target_n_i, ready_i, bus_hold_req_o, count_done_pulse_o, count_done_pulse_oe_n_o, dma_end_o;
  logic [15:0] rsp_rdata_o, system_data_lines_i, system_data_lines_o, wr_seen;
  logic [3:0] dma_grant_n_o;
  int errors = 0, checks_done = 0;
  wire [3:0] strb_low = ~{mem_write_strobe_n_o, mem_read_strobe_n_o, io_write_strobe_n_o, io_read_strobe_n_o};

  isb_bus i_isb_bus (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_kind_i(req_kind_i), .req_write_i(req_write_i), .req_word_i(req_word_i), .req_odd_i(req_odd_i),
    .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_wide_o(rsp_wide_o),
    .system_data_lines_i(system_data_lines_i), .system_data_lines_o(system_data_lines_o),
    .data_lo_oe_n_o(data_lo_oe_n_o), .data_hi_oe_n_o(data_hi_oe_n_o), .upper_byte_enable_n_o(upper_byte_enable_n_o),
    .io_read_strobe_n_o(io_read_strobe_n_o), .io_write_strobe_n_o(io_write_strobe_n_o),
    .mem_read_strobe_n_o(mem_read_strobe_n_o), .mem_write_strobe_n_o(mem_write_strobe_n_o),
    .wide_target_n_i(wide_target_n_i), .ready_i(ready_i), .dma_request_i(dma_request_i),
    .dma_grant_n_o(dma_grant_n_o), .bus_hold_req_o(bus_hold_req_o), .bus_hold_ack_i(bus_hold_ack_i),
    .dma_count_done_i(dma_count_done_i), .pin_out_mode_i(pin_out_mode_i), .process_end_n_i(process_end_n_i),
    .count_done_pulse_o(count_done_pulse_o), .count_done_pulse_oe_n_o(count_done_pulse_oe_n_o),
    .dma_end_o(dma_end_o));

  isb_periph_model i_isb_periph_model (.ref_clk_i(ref_clk_i), .drv_data_i(system_data_lines_o),
    .drv_lo_oe_n_i(data_lo_oe_n_o), .drv_hi_oe_n_i(data_hi_oe_n_o), .io_read_strobe_n_i(io_read_strobe_n_o),
    .io_write_strobe_n_i(io_write_strobe_n_o), .mem_read_strobe_n_i(mem_read_strobe_n_o),
    .mem_write_strobe_n_i(mem_write_strobe_n_o), .wide_en_i(wide_en), .wait_cnt_i(wait_cnt),
    .rd_pattern_i(RD_PAT), .bus_o(system_data_lines_i), .wide_target_n_o(wide_target_n_i),
    .ready_o(ready_i), .wr_seen_o(wr_seen));

  always #2.5 ref_clk_i = ~ref_clk_i;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Strobe history per cycle; overlap is never legal
  always @(posedge ref_clk_i) begin
    if (!rst_i) begin
      // History restarts at the edge that takes a request
      if (req_valid_i && req_ready_o) begin
        strb_seen <= 4'h0;
        upper_seen <= 1'b0;
      end else begin
        strb_seen <= strb_seen | strb_low;
        if (upper_byte_enable_n_o === 1'b0) begin
          upper_seen <= 1'b1;
        end
      end
      if ($countones(strb_low) > 1) begin
        errors++;
        $display("Error strobe_overlap expected 1 seen %0d", $countones(strb_low));
      end
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic bus_op(input isb_kind_type kind, input logic wr, word, odd, wide, input logic [3:0] waits,
                        input logic [15:0] wdata);
    int n;
    logic [15:0] exp_d, got_d;
    n = 0;
    wide_en = wide;
    wait_cnt = waits;
    req_kind_i = kind;
    req_write_i = wr;
    req_word_i = word;
    req_odd_i = odd;
    req_wdata_i = wdata;
    req_valid_i = 1'b1;
    chk("req_ready", 16'h0001, {15'h0, req_ready_o});
    tick;
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    chk("latency", 16'(SETUP_CYC + CMD_CYC + waits), 16'(n));
    if (wide && word) begin
      exp_d = wr ? wdata : RD_PAT;
      got_d = wr ? wr_seen : rsp_rdata_o;
    end else if (odd) begin
      exp_d = {8'h00, wr ? wdata[15:8] : (wide ? RD_PAT[15:8] : RD_PAT[7:0])};
      got_d = {8'h00, wr ? (wide ? wr_seen[15:8] : wr_seen[7:0]) : rsp_rdata_o[15:8]};
    end else begin
      exp_d = {8'h00, wr ? wdata[7:0] : RD_PAT[7:0]};
      got_d = {8'h00, wr ? wr_seen[7:0] : rsp_rdata_o[7:0]};
    end
    chk("data", exp_d, got_d);
    chk("strobe", {12'h0, 4'h1 << {kind, wr}}, {12'h0, strb_seen});
    chk("upper_byte_enable", {15'h0, odd | word}, {15'h0, upper_seen});
    chk("rsp_wide", {15'h0, wide}, {15'h0, rsp_wide_o});
    tick;
  endtask

  task automatic wait_grant(input logic [3:0] exp);
    int n;
    n = 0;
    while (dma_grant_n_o === GRANT_NONE_N && n < 6) begin
      tick;
      n++;
    end
    chk("grant", {12'h0, exp}, {12'h0, dma_grant_n_o});
  endtask

  task automatic test_dma;
    for (int ch = 0; ch < 4; ch++) begin
      dma_request_i = 4'h1 << ch;
      tick;
      tick;
      chk("hold_req", 16'h0001, {15'h0, bus_hold_req_o});
      chk("grant_before_release", {12'h0, GRANT_NONE_N}, {12'h0, dma_grant_n_o});
      chk("req_ready_in_dma", 16'h0000, {15'h0, req_ready_o});
      bus_hold_ack_i = 1'b1;
      wait_grant(~(4'h1 << ch));
      dma_request_i = 4'h0;
      tick;
      tick;
      chk("grant_released", {12'h0, GRANT_NONE_N}, {12'h0, dma_grant_n_o});
      bus_hold_ack_i = 1'b0;
    end
    tick;
    bus_hold_ack_i = 1'b1;
    dma_request_i = 4'b0110;
    wait_grant(4'b1101);
    dma_request_i = 4'b0100;
    tick;
    tick;
    wait_grant(4'b1011);
    dma_request_i = 4'h0;
    tick;
    tick;
    bus_hold_ack_i = 1'b0;
  endtask

  task automatic test_count_pin;
    int n;
    pin_out_mode_i = 1'b1;
    chk("pin_drive_out", 16'h0000, {15'h0, count_done_pulse_oe_n_o});
    dma_count_done_i = 1'b1;
    tick;
    dma_count_done_i = 1'b0;
    chk("count_pulse", 16'h0001, {15'h0, count_done_pulse_o});
    tick;
    chk("count_pulse_end", 16'h0000, {15'h0, count_done_pulse_o});
    process_end_n_i = 1'b0;
    tick;
    tick;
    chk("end_in_out_mode", 16'h0000, {15'h0, dma_end_o});
    process_end_n_i = 1'b1;
    pin_out_mode_i = 1'b0;
    tick;
    chk("pin_drive_end", 16'h0001, {15'h0, count_done_pulse_oe_n_o});
    dma_count_done_i = 1'b1;
    tick;
    dma_count_done_i = 1'b0;
    chk("count_in_end_mode", 16'h0000, {15'h0, count_done_pulse_o});
    bus_hold_ack_i = 1'b1;
    dma_request_i = 4'h8;
    wait_grant(4'b0111);
    process_end_n_i = 1'b0;
    n = 0;
    while (dma_end_o !== 1'b1 && n < 4) begin
      tick;
      n++;
    end
    chk("end_pulse", 16'h0001, {15'h0, dma_end_o});
    tick;
    chk("end_pulse_single", 16'h0000, {15'h0, dma_end_o});
    dma_request_i = 4'h0;
    tick;
    chk("grant_after_end", {12'h0, GRANT_NONE_N}, {12'h0, dma_grant_n_o});
    bus_hold_ack_i = 1'b0;
    process_end_n_i = 1'b1;
    tick;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) tick;
    chk("strobes_in_reset", 16'h0000, {12'h0, strb_low});
    chk("grants_in_reset", {12'h0, GRANT_NONE_N}, {12'h0, dma_grant_n_o});
    chk("oe_in_reset", 16'h0003, {14'h0, data_hi_oe_n_o, data_lo_oe_n_o});
    rst_i = 1'b0;
    tick;
    bus_op(KIND_IO, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    bus_op(KIND_IO, 1'b1, 1'b0, 1'b1, 1'b0, 4'h2, 16'h5A00);
    bus_op(KIND_MEM, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 16'h0000);
    bus_op(KIND_MEM, 1'b1, 1'b1, 1'b0, 1'b1, 4'h1, 16'h9E37);
    bus_op(KIND_MEM, 1'b0, 1'b0, 1'b1, 1'b0, 4'h3, 16'h0000);
    bus_op(KIND_IO, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 16'h7100);
    bus_op(KIND_IO, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
    test_dma;
    test_count_pin;
    report_and_stop;
  end

  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule
